// [include/ssf_defs.vh]
// Notes on behaviour
// R01: A parity mismatch on a received frame sets status bit 3 and ends reception.
// R02: A parity-faulted character still lands in the receive holding register, flag stays clear.
// R03: While parity fault is set, reception stops; clocked mode also halts transmission.
// R04: Writing one does nothing; writing zero after reading one clears the flag.
// R05: Dropping receiver enable leaves the parity fault flag as it was.
// R06: Transmit done, bit 2, resets to one; set when transmitter off or last bit sent empty.
// R07: Transmit done clears with software empty-flag clear or a DMA write of transmit data.
// R08: Multiprocessor receive bit, bit 1, resets to zero, follows each stored frame, kept on disable.
// R09: Multiprocessor transmit bit, bit 0, resets to zero and goes out with each frame.
// R10: Transmit holding empty, bit 7, resets to one and shows no pending transmit data.
// R11: Transmit holding empty sets while transmitter off and on each move to shifter.
// R12: Transmit holding empty clears by software sequence or a DMA write of transmit data.
// R13: Receive holding full, bit 6, resets to zero; sets on normal end of reception.
// R14: Receive holding full clears by software sequence or a DMA read of received data.
// R15: Dropping receiver enable leaves the receive holding full flag as it was.
// R16: A frame completing while receive holding full is set raises overrun and is dropped.
// R17: Software reads a flag back after clearing it while its interrupt is enabled.
// R18: On overrun the receive holding register keeps the older character; overrun flag sets.
// R19: A zero first stop bit raises a framing fault; a second stop bit is not checked.
// R20: Transmit-empty and receive-full requests follow their flags when enabled.
`ifndef SSF_DEFS_VH
`define SSF_DEFS_VH

// ****************************************************************
// Register offsets
// ****************************************************************
`define SSF_ADDR_W 4
`define SSF_OFS_CONTROL 4'h0
`define SSF_OFS_STATUS 4'h4
`define SSF_OFS_TX_HOLD 4'h8
`define SSF_OFS_RX_HOLD 4'hc

// ****************************************************************
// Control fields
// ****************************************************************
`define SSF_CTL_TX_EN 0
`define SSF_CTL_RX_EN 1
`define SSF_CTL_TX_IE 2
`define SSF_CTL_RX_IE 3
`define SSF_CTL_SYNC 4
`define SSF_CONTROL_RESET 8'h00
`define SSF_CONTROL_MASK 8'h1f

// ****************************************************************
// Status fields
// ****************************************************************
`define SSF_ST_TX_EMPTY 7
`define SSF_ST_RX_FULL 6
`define SSF_ST_OVERRUN 5
`define SSF_ST_FRAMING 4
`define SSF_ST_PARITY 3
`define SSF_ST_TX_DONE 2
`define SSF_ST_MP_RX 1
`define SSF_ST_MP_TX 0
`define SSF_STATUS_RESET 8'h84
`define SSF_CLR_LO 3
`define SSF_CLR_N 5

`endif

// [src/ssf_clr_flag.v]
`timescale 1ns/10ps
`include "ssf_defs.vh"

module ssf_clr_flag #(
  parameter RESET_VAL = 1'b0
) (
  input wire clk_sys,
  input wire arst_n,
  input wire set,
  input wire hw_clear,
  input wire st_read,
  input wire st_write,
  input wire wr_bit,
  output reg flag,
  output wire sw_clear
);

  // A read that sees the flag at one arms the clear; any later status write disarms it.
  reg armed;

  assign sw_clear = st_write & ~wr_bit & armed; // R04

  always @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      armed <= 1'b0;
    end
    else if (st_write)
    begin
      armed <= 1'b0;
    end
    else if (st_read & flag)
    begin
      armed <= 1'b1; // R04
    end
  end

  // The set wins so that an event in the clearing cycle is not lost.
  always @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      flag <= RESET_VAL;
    end
    else if (set)
    begin
      flag <= 1'b1;
    end
    else if (hw_clear | sw_clear)
    begin
      flag <= 1'b0; // R04
    end
  end

endmodule // ssf_clr_flag

// [src/ssf_status.v]
`timescale 1ns/10ps
`include "ssf_defs.vh"

module ssf_status #(
  parameter DATA_W = 8
) (
  input wire clk_sys,
  input wire arst_n,
  input wire [`SSF_ADDR_W-1:0] reg_addr,
  input wire [DATA_W-1:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [DATA_W-1:0] reg_rdata,
  input wire dma_tx_wr,
  input wire [DATA_W-1:0] dma_tx_data,
  input wire dma_rx_rd,
  output reg [DATA_W-1:0] rx_holding,
  input wire rx_done,
  input wire [DATA_W-1:0] rx_char,
  input wire rx_parity_bad,
  input wire rx_stop_bit,
  input wire rx_mp_bit,
  output reg rx_run,
  input wire tx_shift_idle,
  input wire tx_last_bit,
  output reg tx_load,
  output reg [DATA_W-1:0] tx_char,
  output reg tx_mp_bit,
  output reg tx_halt,
  output reg tx_empty_request,
  output reg rx_full_request,
  output reg [DATA_W-1:0] status_out
);

  // ****************************************************************
  // Register decode
  // ****************************************************************
  wire ctl_wr;
  wire st_wr;
  wire st_rd;
  wire txh_wr;

  assign ctl_wr = reg_wr & (reg_addr == `SSF_OFS_CONTROL);
  assign st_wr = reg_wr & (reg_addr == `SSF_OFS_STATUS);
  assign st_rd = reg_rd & (reg_addr == `SSF_OFS_STATUS);
  assign txh_wr = reg_wr & (reg_addr == `SSF_OFS_TX_HOLD);

  // ****************************************************************
  // Control register
  // ****************************************************************
  reg [DATA_W-1:0] serial_control_reg;
  wire transmitter_enable_bit;
  wire receiver_enable_bit;
  wire tx_int_en;
  wire rx_int_en;
  wire sync_mode;

  always @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      serial_control_reg <= `SSF_CONTROL_RESET;
    end
    else if (ctl_wr)
    begin
      serial_control_reg <= reg_wdata & `SSF_CONTROL_MASK;
    end
  end

  assign transmitter_enable_bit = serial_control_reg[`SSF_CTL_TX_EN];
  assign receiver_enable_bit = serial_control_reg[`SSF_CTL_RX_EN];
  assign tx_int_en = serial_control_reg[`SSF_CTL_TX_IE];
  assign rx_int_en = serial_control_reg[`SSF_CTL_RX_IE];
  assign sync_mode = serial_control_reg[`SSF_CTL_SYNC];

  // ****************************************************************
  // Clearable flags
  // ****************************************************************
  // Index 0 to 4 maps onto status bits 3 to 7.
  localparam [7:0] ST_RESET = `SSF_STATUS_RESET;
  localparam I_PER = `SSF_ST_PARITY - `SSF_CLR_LO;
  localparam I_FER = `SSF_ST_FRAMING - `SSF_CLR_LO;
  localparam I_OVERRUN_FAULT_FLAG = `SSF_ST_OVERRUN - `SSF_CLR_LO;
  localparam I_RXF = `SSF_ST_RX_FULL - `SSF_CLR_LO;
  localparam I_TXE = `SSF_ST_TX_EMPTY - `SSF_CLR_LO;

  reg [`SSF_CLR_N-1:0] flag_set;
  reg [`SSF_CLR_N-1:0] flag_hw_clr;
  wire [`SSF_CLR_N-1:0] flag_val;
  wire [`SSF_CLR_N-1:0] flag_sw_clr;

  genvar gi;
  generate
    for (gi = 0; gi < `SSF_CLR_N; gi = gi + 1)
    begin : g_flag
      ssf_clr_flag #(
        .RESET_VAL(ST_RESET[gi+`SSF_CLR_LO])
      ) u_flag (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .set(flag_set[gi]),
        .hw_clear(flag_hw_clr[gi]),
        .st_read(st_rd),
        .st_write(st_wr),
        .wr_bit(reg_wdata[gi+`SSF_CLR_LO]),
        .flag(flag_val[gi]),
        .sw_clear(flag_sw_clr[gi])
      );
    end
  endgenerate

  wire parity_fault_flag;
  wire framing_fault_flag;
  wire overrun_fault_flag;
  wire rx_holding_full_flag;
  wire tx_holding_empty_flag;
  wire rx_blocked;

  assign parity_fault_flag = flag_val[I_PER];
  assign framing_fault_flag = flag_val[I_FER];
  assign overrun_fault_flag = flag_val[I_OVERRUN_FAULT_FLAG];
  assign rx_holding_full_flag = flag_val[I_RXF];
  assign tx_holding_empty_flag = flag_val[I_TXE];

  // Any error flag stops the receiver until software clears it.
  assign rx_blocked = parity_fault_flag | framing_fault_flag | overrun_fault_flag; // R03

  // ****************************************************************
  // Receive path
  // ****************************************************************
  // Frames are ignored while the receiver is off or an error flag stands.
  // The receiver enable bit is never used to clear a flag here.
  wire rx_take;
  wire rx_overrun;
  wire rx_framing;
  wire rx_parity;
  wire rx_normal;
  wire rx_store;

  assign rx_take = rx_done & receiver_enable_bit & ~rx_blocked; // R03
  assign rx_overrun = rx_take & rx_holding_full_flag; // R16
  assign rx_framing = rx_take & ~rx_holding_full_flag & ~rx_stop_bit; // R19
  assign rx_parity = rx_take & ~rx_holding_full_flag & rx_parity_bad; // R01
  assign rx_normal = rx_take & ~rx_holding_full_flag & rx_stop_bit & ~rx_parity_bad; // R13
  assign rx_store = rx_take & ~rx_holding_full_flag; // R02

  always @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rx_holding <= {DATA_W{1'b0}};
    end
    else if (rx_store)
    begin
      rx_holding <= rx_char; // R02
    end
  end

  // The older character stays put on overrun because rx_store excludes it.
  reg multiproc_rx_bit;

  always @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      multiproc_rx_bit <= 1'b0;
    end
    else if (rx_store)
    begin
      multiproc_rx_bit <= rx_mp_bit; // R08
    end
  end

  // ****************************************************************
  // Transmit path
  // ****************************************************************
  reg [DATA_W-1:0] tx_holding_reg;
  reg multiproc_tx_bit;
  reg transmit_done_flag;
  wire next_tx_load;

  always @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tx_holding_reg <= {DATA_W{1'b0}};
    end
    else if (dma_tx_wr)
    begin
      tx_holding_reg <= dma_tx_data;
    end
    else if (txh_wr)
    begin
      tx_holding_reg <= reg_wdata;
    end
  end

  always @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      multiproc_tx_bit <= 1'b0;
    end
    else if (st_wr)
    begin
      multiproc_tx_bit <= reg_wdata[`SSF_ST_MP_TX]; // R09
    end
  end

  // A character moves to the shifter only when one is pending and the shifter
  // is idle; the guard on tx_load keeps one character from leaving twice.
  assign next_tx_load = transmitter_enable_bit & ~tx_holding_empty_flag & tx_shift_idle
                        & ~tx_halt & ~tx_load;

  always @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tx_load <= 1'b0;
      tx_char <= {DATA_W{1'b0}};
      tx_mp_bit <= 1'b0;
    end
    else
    begin
      tx_load <= next_tx_load;
      if (next_tx_load)
      begin
        tx_char <= tx_holding_reg;
        tx_mp_bit <= multiproc_tx_bit; // R09
      end
    end
  end

  // Transmit done is read-only, so it needs no clearing sequence of its own.
  wire transmit_done_flag_set;
  wire transmit_done_flag_clr;

  assign transmit_done_flag_set = ~transmitter_enable_bit | (tx_last_bit & tx_holding_empty_flag); // R06
  assign transmit_done_flag_clr = flag_sw_clr[I_TXE] | dma_tx_wr; // R07

  always @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      transmit_done_flag <= ST_RESET[`SSF_ST_TX_DONE]; // R06
    end
    else if (transmit_done_flag_set)
    begin
      transmit_done_flag <= 1'b1;
    end
    else if (transmit_done_flag_clr)
    begin
      transmit_done_flag <= 1'b0; // R07
    end
  end

  // ****************************************************************
  // Flag events
  // ****************************************************************
  always @*
  begin
    flag_set = {`SSF_CLR_N{1'b0}};
    flag_hw_clr = {`SSF_CLR_N{1'b0}}; // R05 R15
    flag_set[I_PER] = rx_parity; // R01
    flag_set[I_FER] = rx_framing; // R19
    flag_set[I_OVERRUN_FAULT_FLAG] = rx_overrun; // R18
    flag_set[I_RXF] = rx_normal; // R13
    flag_set[I_TXE] = ~transmitter_enable_bit | tx_load; // R11
    flag_hw_clr[I_RXF] = dma_rx_rd; // R14
    flag_hw_clr[I_TXE] = dma_tx_wr; // R12
  end

  // ****************************************************************
  // Status image
  // ****************************************************************
  wire [DATA_W-1:0] status_now;

  assign status_now = {tx_holding_empty_flag, // R10
                       rx_holding_full_flag,
                       overrun_fault_flag,
                       framing_fault_flag,
                       parity_fault_flag,
                       transmit_done_flag,
                       multiproc_rx_bit,
                       multiproc_tx_bit};

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // Requests run one cycle behind the flags, so a servicing DMA may see a
  // request for one cycle after its own transfer.
  always @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rx_run <= 1'b0;
      tx_halt <= 1'b0;
      tx_empty_request <= 1'b0;
      rx_full_request <= 1'b0;
      status_out <= `SSF_STATUS_RESET;
    end
    else
    begin
      rx_run <= receiver_enable_bit & ~rx_blocked; // R03
      tx_halt <= sync_mode & rx_blocked; // R03
      tx_empty_request <= tx_int_en & transmitter_enable_bit & tx_holding_empty_flag; // R20
      rx_full_request <= rx_int_en & rx_holding_full_flag; // R20
      status_out <= status_now;
    end
  end

  // ****************************************************************
  // Read data
  // ****************************************************************
  // The status read shows the value before any change in the same cycle.
  reg [DATA_W-1:0] next_rdata;

  always @*
  begin
    next_rdata = {DATA_W{1'b0}};
    case (reg_addr)
      `SSF_OFS_CONTROL:
      begin
        next_rdata = serial_control_reg;
      end
      `SSF_OFS_STATUS:
      begin
        next_rdata = status_now;
      end
      `SSF_OFS_TX_HOLD:
      begin
        next_rdata = tx_holding_reg;
      end
      `SSF_OFS_RX_HOLD:
      begin
        next_rdata = rx_holding;
      end
      default:
      begin
        next_rdata = {DATA_W{1'b0}};
      end
    endcase
  end

  always @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      reg_rdata <= {DATA_W{1'b0}};
    end
    else if (reg_rd)
    begin
      reg_rdata <= next_rdata;
    end
    else
    begin
      reg_rdata <= {DATA_W{1'b0}};
    end
  end

endmodule // ssf_status

// [verification/ssf_status_chk.sv]
`timescale 1ns/10ps
// ****************************************************************
// Status flag checker
// ****************************************************************
module ssf_status_chk #(
  parameter DATA_W = 8
) (
  input wire clk_sys,
  input wire arst_n,
  input wire reg_rd,
  input wire [DATA_W-1:0] reg_rdata,
  input wire dma_tx_wr,
  input wire dma_rx_rd,
  input wire rx_done,
  input wire rx_parity_bad,
  input wire rx_stop_bit,
  input wire rx_run,
  input wire tx_shift_idle,
  input wire tx_load,
  input wire tx_halt,
  input wire tx_empty_request,
  input wire rx_full_request,
  input wire [DATA_W-1:0] status_out
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  // The status copy lags the flags by one cycle, hence the extra delay.
  property p_rx_full;
    rx_done && rx_run && !rx_parity_bad && rx_stop_bit && !dma_rx_rd |=> ##1 status_out[6];
  endproperty
  a_rx_full: assert property (p_rx_full) else $error("rx full not set");
  property p_parity;
    rx_done && rx_run && rx_parity_bad |=> ##1 (status_out[3] && !rx_run);
  endproperty
  a_parity: assert property (p_parity) else $error("parity fault missed");
  property p_framing;
    rx_done && rx_run && !rx_stop_bit |=> ##1 status_out[4];
  endproperty
  a_framing: assert property (p_framing) else $error("framing fault missed");
  property p_load_empty;
    tx_load |=> !tx_load ##1 status_out[7];
  endproperty
  a_load_empty: assert property (p_load_empty) else $error("load did not empty");
  property p_load_cause;
    $rose(tx_load) |-> $past(tx_shift_idle) && !$past(tx_halt);
  endproperty
  a_load_cause: assert property (p_load_cause) else $error("load while halted");
  property p_dma_tx;
    dma_tx_wr && tx_empty_request |=> ##1 (status_out[7:7] == 1'h0 && !status_out[2]);
  endproperty
  a_dma_tx: assert property (p_dma_tx) else $error("dma write kept flags");
  property p_dma_rx;
    dma_rx_rd && !rx_done |=> ##1 !status_out[6];
  endproperty
  a_dma_rx: assert property (p_dma_rx) else $error("dma read kept full");
  property p_tx_req;
    tx_empty_request |-> status_out[7];
  endproperty
  a_tx_req: assert property (p_tx_req) else $error("tx request without empty");
  property p_rx_req;
    rx_full_request |-> status_out[6];
  endproperty
  a_rx_req: assert property (p_rx_req) else $error("rx request without full");
  property p_rdata_idle;
    !$past(reg_rd) |-> reg_rdata == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside slot");
endmodule // ssf_status_chk

bind ssf_status ssf_status_chk #(.DATA_W(DATA_W)) u_chk (.*);

// [verification/ssf_tx_station.sv]
`timescale 1ns/10ps
// ****************************************************************
// Far-side transmit engine model
// ****************************************************************
module ssf_tx_station (
  input wire clk_sys,
  input wire arst_n,
  input wire slow,
  input wire tx_load,
  input wire [7:0] tx_char,
  input wire tx_mp_bit,
  output reg tx_shift_idle,
  output reg tx_last_bit,
  output reg [7:0] last_char,
  output reg last_mp
);
  // A slow station keeps the shifter busy so flags can be seen mid-frame.
  reg [4:0] cnt;
  always @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tx_shift_idle <= 1'h1;
      tx_last_bit <= 1'h0;
      cnt <= 5'h00;
      last_char <= 8'h00;
      last_mp <= 1'h0;
    end
    else
    begin
      tx_last_bit <= (cnt == 5'h01);
      if (cnt != 5'h00)
        cnt <= cnt - 5'h01;
      if (cnt == 5'h01)
        tx_shift_idle <= 1'h1;
      if (tx_load)
      begin
        tx_shift_idle <= 1'h0;
        cnt <= slow ? 5'h14 : 5'h04;
        last_char <= tx_char;
        last_mp <= tx_mp_bit;
      end
    end
  end
endmodule // ssf_tx_station

// [verification/ssf_status_bench.sv]
`timescale 1ns/10ps
// ****************************************************************
// Status flag bench
// ****************************************************************
module ssf_status_bench;
  reg clk_sys = 1'h0;
  reg arst_n = 1'h0;
  reg [3:0] reg_addr = 4'h0;
  reg [7:0] reg_wdata = 8'h00, dma_tx_data = 8'h00, rx_char = 8'h00, rdata_seen = 8'h00;
  reg reg_wr = 1'h0, reg_rd = 1'h0, dma_tx_wr = 1'h0, dma_rx_rd = 1'h0, rx_done = 1'h0;
  reg rx_parity_bad = 1'h0, rx_stop_bit = 1'h1, rx_mp_bit = 1'h0, slow = 1'h0;
  wire [7:0] reg_rdata, rx_holding, tx_char, status_out, last_char;
  wire rx_run, tx_shift_idle, tx_last_bit, tx_load, tx_mp_bit, tx_halt, last_mp;
  wire tx_empty_request, rx_full_request;
  integer miscompares = 0, n_compared = 0, i;
  reg [18:0] rows [0:3];
  ssf_status DUT (.*);
  ssf_tx_station u_peer (.*);
  always #50 clk_sys = ~clk_sys;
  task chk(input [7:0] got, input [7:0] exp);
  begin
    n_compared = n_compared + 1;
    if (got !== exp)
    begin
      miscompares = miscompares + 1;
      $display("FAIL at %0t: got %h, expected %h", $time, got, exp);
    end
  end
  endtask
  // One strobe cycle, then one quiet cycle, so no strobe lingers into the
  // frame or DMA stimulus that follows; read data is taken while it stands.
  task bus(input w, input r, input [3:0] a, input [7:0] d);
  begin
    reg_wr <= w;
    reg_rd <= r;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    #1;
    rdata_seen = reg_rdata;
    reg_wr <= 1'h0;
    reg_rd <= 1'h0;
    @(posedge clk_sys);
    #1;
  end
  endtask
  task idle(input integer n);
  begin
    reg_wr <= 1'h0;
    reg_rd <= 1'h0;
    rx_done <= 1'h0;
    dma_tx_wr <= 1'h0;
    dma_rx_rd <= 1'h0;
    repeat (n) @(posedge clk_sys);
    #1;
  end
  endtask
  task rd(input [3:0] a, input [7:0] e);
  begin
    bus(1'h0, 1'h1, a, 8'h00);
    chk(rdata_seen, e);
  end
  endtask
  task wr_ctl(input [7:0] d);
  begin
    bus(1'h1, 1'h0, 4'h0, d);
  end
  endtask
  task clear(input [7:0] d);
  begin
    bus(1'h0, 1'h1, 4'h4, 8'h00);
    bus(1'h1, 1'h0, 4'h4, d);
  end
  endtask
  task frame(input [7:0] c, input pb, input st, input mp);
  begin
    rx_char <= c;
    rx_parity_bad <= pb;
    rx_stop_bit <= st;
    rx_mp_bit <= mp;
    rx_done <= 1'h1;
    @(posedge clk_sys);
    #1;
    rx_char <= ~c;
    rx_mp_bit <= ~mp;
    idle(2);
  end
  endtask
  task wait_done;
  begin
    for (i = 0; i < 100 && status_out[2] !== 1'h1; i = i + 1)
      @(posedge clk_sys);
    #1;
  end
  endtask
  task summarize;
  begin
    $display("compared %0d, mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  end
  endtask
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    miscompares = miscompares + 1;
    summarize;
  end
  initial
  begin
    rows[0] = {8'h5a, 3'h3, 8'hc6};
    rows[1] = {8'ha5, 3'h6, 8'h8c};
    rows[2] = {8'h3c, 3'h1, 8'h96};
    rows[3] = {8'hc3, 3'h4, 8'h9c};
    repeat (16) @(posedge clk_sys);
    arst_n <= 1'h1;
    idle(1);
    chk(status_out, 8'h84);
    rd(4'h4, 8'h84);
    rd(4'h2, 8'h00);
    rd(4'hc, 8'h00);
    wr_ctl(8'h02);
    for (i = 0; i < 4; i = i + 1)
    begin
      frame(rows[i][18:11], rows[i][10], rows[i][9], rows[i][8]);
      rd(4'h4, rows[i][7:0]);
      rd(4'hc, rows[i][18:11]);
      clear(8'h00);
      rd(4'h4, {6'h21, rows[i][8], 1'h0});
    end
    $display("test rows done");
    frame(8'h11, 1'h0, 1'h1, 1'h1);
    bus(1'h1, 1'h0, 4'h4, 8'h00);
    rd(4'h4, 8'hc6);
    bus(1'h1, 1'h0, 4'h4, 8'hf9);
    bus(1'h1, 1'h0, 4'h4, 8'h01);
    rd(4'h4, 8'hc7);
    bus(1'h1, 1'h0, 4'h4, 8'h01);
    rd(4'h4, 8'h87);
    $display("test clear rules done");
    frame(8'h22, 1'h0, 1'h1, 1'h0);
    frame(8'h33, 1'h0, 1'h1, 1'h1);
    frame(8'h44, 1'h0, 1'h1, 1'h1);
    rd(4'hc, 8'h22);
    rd(4'h4, 8'he5);
    chk(rx_holding, 8'h22);
    chk({7'h00, rx_run}, 8'h00);
    clear(8'h00);
    rd(4'h4, 8'h84);
    $display("test overrun done");
    frame(8'h55, 1'h1, 1'h1, 1'h1);
    wr_ctl(8'h00);
    rd(4'h4, 8'h8e);
    rd(4'hc, 8'h55);
    wr_ctl(8'h0a);
    clear(8'h00);
    frame(8'h66, 1'h0, 1'h1, 1'h0);
    chk({7'h00, rx_full_request}, 8'h01);
    wr_ctl(8'h08);
    rd(4'h4, 8'hc4);
    chk({7'h00, rx_full_request}, 8'h01);
    dma_rx_rd <= 1'h1;
    @(posedge clk_sys);
    #1;
    idle(2);
    chk({7'h00, rx_full_request}, 8'h00);
    rd(4'h4, 8'h84);
    $display("test receive done");
    bus(1'h1, 1'h0, 4'h8, 8'h96);
    wr_ctl(8'h07);
    rd(4'h4, 8'h84);
    bus(1'h1, 1'h0, 4'h4, 8'h01);
    rd(4'h4, 8'h01);
    wait_done;
    chk(last_char, 8'h96);
    chk({7'h00, last_mp}, 8'h01);
    rd(4'h4, 8'h85);
    chk({7'h00, tx_empty_request}, 8'h01);
    slow <= 1'h1;
    dma_tx_data <= 8'h69;
    dma_tx_wr <= 1'h1;
    @(posedge clk_sys);
    #1;
    idle(0);
    rd(4'h4, 8'h01);
    wait_done;
    chk(last_char, 8'h69);
    rd(4'h4, 8'h85);
    $display("test transmit done");
    wr_ctl(8'h13);
    frame(8'h77, 1'h1, 1'h1, 1'h0);
    chk({7'h00, tx_halt}, 8'h01);
    bus(1'h1, 1'h0, 4'h8, 8'h5a);
    clear(8'h08);
    idle(4);
    chk(last_char, 8'h69);
    clear(8'h80);
    idle(2);
    chk({7'h00, tx_halt}, 8'h00);
    wait_done;
    chk(last_char, 8'h5a);
    rd(4'h4, 8'h84);
    arst_n <= 1'h0;
    idle(2);
    arst_n <= 1'h1;
    idle(1);
    rd(4'h4, 8'h84);
    rd(4'h0, 8'h00);
    $display("test halt and reset done");
    summarize;
  end
endmodule // ssf_status_bench
